/* hw/ccvg_pkg.sv */
// package of constants and carriers for the crosshair cursor video generator
package ccvg_pkg;

	// counter widths
	localparam int ELEM_W = 10;
	localparam int LINE_W = 9;

	// field counts per blink-clock step; 4 steps make one blink period
	localparam int FIELDS_PER_STEP = 15;

	// register byte addresses
	localparam logic [3:0] ADDR_ELEM = 4'h0;
	localparam logic [3:0] ADDR_LINE = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam int ADDR_W = 4;

	// line register field positions
	localparam int LINE_COORD_LSB = 0;
	localparam int LINE_ENTER_BIT = 12;
	localparam int LINE_TRACK_BIT = 13;
	localparam int LINE_FLASH_BIT = 14;
	localparam int LINE_SHOW_BIT = 15;

	// status register field positions
	localparam int STAT_ELEM_LSB = 0;
	localparam int STAT_LINE_LSB = 16;
	localparam int STAT_EDIR_BIT = 26;
	localparam int STAT_LDIR_BIT = 27;
	localparam int STAT_FLASH_LSB = 28;

	// decoder bit ranges
	localparam int HWIN_HI = 9;
	localparam int HWIN_LO = 3;
	localparam int HSTR_HI = 2;
	localparam int VWIN_HI = 8;
	localparam int VWIN_LO = 3;
	localparam int VSTR_HI = 2;
	localparam int VSTR_LO = 1;

	// reset values
	localparam logic [ELEM_W-1:0] ELEM_RST = 10'h000;
	localparam logic [LINE_W-1:0] LINE_RST = 9'h000;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// raster timing inputs, all on aclk
	typedef struct packed {
		logic horiz_blank_level;
		logic horiz_mem_sync_pulse;
		logic vert_blank_level;
		logic vert_mem_sync_pulse;
		logic odd_field;
	} ccvg_timing_t;

	// stored cursor line register
	typedef struct packed {
		logic cursor_show_bit;
		logic cursor_flash_bit;
		logic track;
		logic enter;
		logic [LINE_W-1:0] coord;
	} ccvg_line_reg_t;

endpackage

/* hw/ccvg_top.sv */
// crosshair cursor video generator with an AXI4-Lite register slave
module ccvg_top #(
	parameter int FIELDS_PER_STEP = ccvg_pkg::FIELDS_PER_STEP
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// raster timing from the display timing logic
	input wire ccvg_pkg::ccvg_timing_t timing,
	// cursor picture out
	output logic cursor_video,
	// axi4-lite write address
	input wire logic [ccvg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ccvg_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int EW = ccvg_pkg::ELEM_W;
	localparam int LW = ccvg_pkg::LINE_W;
	localparam int STEP_W = $clog2(FIELDS_PER_STEP + 1);

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// pack the stored line register into its bus word; the struct is
	// narrower than the word, so every field is placed by its position
	function automatic logic [31:0] line_to_word(input ccvg_pkg::ccvg_line_reg_t lr);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[ccvg_pkg::LINE_COORD_LSB +: LW] = lr.coord;
		w[ccvg_pkg::LINE_ENTER_BIT] = lr.enter;
		w[ccvg_pkg::LINE_TRACK_BIT] = lr.track;
		w[ccvg_pkg::LINE_FLASH_BIT] = lr.cursor_flash_bit;
		w[ccvg_pkg::LINE_SHOW_BIT] = lr.cursor_show_bit;
		return w;
	endfunction

	// unpack a bus word into the line register fields
	function automatic ccvg_pkg::ccvg_line_reg_t word_to_line(input logic [31:0] w);
		ccvg_pkg::ccvg_line_reg_t lr;
		lr.coord = w[ccvg_pkg::LINE_COORD_LSB +: LW];
		lr.enter = w[ccvg_pkg::LINE_ENTER_BIT];
		lr.track = w[ccvg_pkg::LINE_TRACK_BIT];
		lr.cursor_flash_bit = w[ccvg_pkg::LINE_FLASH_BIT];
		lr.cursor_show_bit = w[ccvg_pkg::LINE_SHOW_BIT];
		return lr;
	endfunction

	// stored registers
	logic [EW-1:0] elem_coord_q;
	ccvg_pkg::ccvg_line_reg_t line_reg_q;

	// element generator state
	logic [EW-1:0] elem_cnt_q;
	logic elem_dir_up;
	logic elem_zero_hold;
	logic horiz_window;
	logic horiz_stripe;

	// line generator state
	logic [LW-1:0] line_cnt_q;
	logic line_dir_up;
	logic line_zero_detect;
	logic vert_blank_reclocked;
	logic odd_field_bump;
	logic line_coord_lsb;
	logic vert_window;
	logic vert_stripe;
	logic line_tick;

	// blink clock
	logic [STEP_W-1:0] step_cnt_q;
	logic flash_count_q0;
	logic flash_count_q1;
	logic blink_gate;
	logic cursor_video_q;

	// bus state
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_go;
	logic rd_go;
	logic [31:0] status_word;

	// element counter: preset in blanking, count visible elements
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			elem_cnt_q <= ccvg_pkg::ELEM_RST;
			elem_dir_up <= 1'b0;
		end else if (timing.horiz_mem_sync_pulse) begin
			elem_cnt_q <= elem_coord_q;
			elem_dir_up <= 1'b0;
		end else if (!timing.horiz_blank_level) begin
			if (elem_zero_hold) begin
				elem_dir_up <= 1'b1;
			end else if (elem_dir_up) begin
				elem_cnt_q <= elem_cnt_q + 1'b1;
			end else begin
				elem_cnt_q <= elem_cnt_q - 1'b1;
			end
		end
	end

	// zero-stop only while still heading down, so it drops on reversal
	assign elem_zero_hold = !elem_dir_up && (elem_cnt_q == '0);

	// element decode
	assign horiz_window = (elem_cnt_q[ccvg_pkg::HWIN_HI:ccvg_pkg::HWIN_LO] == '0)
		&& !(&elem_cnt_q[ccvg_pkg::HSTR_HI:0]);
	assign horiz_stripe = (elem_cnt_q[ccvg_pkg::HSTR_HI:0] == '0);

	// reclocked vertical blanking as the main line enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vert_blank_reclocked <= 1'b1;
		end else begin
			vert_blank_reclocked <= timing.vert_blank_level;
		end
	end

	// one-line bump right after the preset, odd fields and odd coords
	assign line_coord_lsb = line_reg_q.coord[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			odd_field_bump <= 1'b0;
		end else begin
			odd_field_bump <= timing.vert_mem_sync_pulse && timing.odd_field
				&& line_coord_lsb;
		end
	end

	// one line step per horizontal sync outside vertical blanking
	assign line_tick = timing.horiz_mem_sync_pulse && !vert_blank_reclocked;
	assign line_zero_detect = !line_dir_up && (line_cnt_q == '0);

	// line counter: preset, bump, then down to centre and back up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_cnt_q <= ccvg_pkg::LINE_RST;
			line_dir_up <= 1'b0;
		end else if (timing.vert_mem_sync_pulse) begin
			line_cnt_q <= line_reg_q.coord;
			line_dir_up <= 1'b0;
		end else if (odd_field_bump) begin
			line_cnt_q <= line_cnt_q + 1'b1;
		end else if (line_tick) begin
			if (line_zero_detect) begin
				// centre line lasts one line: reverse and step in one go
				line_dir_up <= 1'b1;
				line_cnt_q <= line_cnt_q + 1'b1;
			end else if (line_dir_up) begin
				line_cnt_q <= line_cnt_q + 1'b1;
			end else begin
				line_cnt_q <= line_cnt_q - 1'b1;
			end
		end
	end

	// line decode
	assign vert_window = (line_cnt_q[ccvg_pkg::VWIN_HI:ccvg_pkg::VWIN_LO] == '0);
	assign vert_stripe = (line_cnt_q[ccvg_pkg::VSTR_HI:ccvg_pkg::VSTR_LO] == '0);

	// blink clock: a field prescaler then two stages; prescale keeps
	// the period near one second at field rates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_cnt_q <= '0;
			flash_count_q0 <= 1'b0;
			flash_count_q1 <= 1'b0;
		end else if (timing.vert_mem_sync_pulse) begin
			if (step_cnt_q == STEP_W'(FIELDS_PER_STEP - 1)) begin
				step_cnt_q <= '0;
				flash_count_q0 <= !flash_count_q0;
				flash_count_q1 <= flash_count_q1 ^ flash_count_q0;
			end else begin
				step_cnt_q <= step_cnt_q + 1'b1;
			end
		end
	end

	// blink decode: off in one step of four when flashing
	assign blink_gate = line_reg_q.cursor_show_bit
		&& (!line_reg_q.cursor_flash_bit || flash_count_q0 || flash_count_q1);

	// composite crosshair, registered so it lands one element late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cursor_video_q <= 1'b0;
		end else begin
			cursor_video_q <= ((horiz_window && vert_stripe)
				|| (vert_window && horiz_stripe)) && blink_gate;
		end
	end
	assign cursor_video = cursor_video_q;

	// write address and data are taken together, one write at a time
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;

	// stored cursor registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			elem_coord_q <= ccvg_pkg::ELEM_RST;
			line_reg_q <= '0;
		end else if (wr_go) begin
			case (s_axi_awaddr)
				ccvg_pkg::ADDR_ELEM: begin
					elem_coord_q <= EW'(merge_bytes(32'(elem_coord_q), s_axi_wdata,
						s_axi_wstrb));
				end
				ccvg_pkg::ADDR_LINE: begin
					line_reg_q <= word_to_line(merge_bytes(line_to_word(line_reg_q),
						s_axi_wdata, s_axi_wstrb));
				end
				default: begin
				end
			endcase
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= ccvg_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= (s_axi_awaddr == ccvg_pkg::ADDR_ELEM
				|| s_axi_awaddr == ccvg_pkg::ADDR_LINE)
				? ccvg_pkg::RESP_OKAY : ccvg_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// live generator state for software
	always_comb begin
		status_word = '0;
		status_word[ccvg_pkg::STAT_ELEM_LSB +: EW] = elem_cnt_q;
		status_word[ccvg_pkg::STAT_LINE_LSB +: LW] = line_cnt_q;
		status_word[ccvg_pkg::STAT_EDIR_BIT] = elem_dir_up;
		status_word[ccvg_pkg::STAT_LDIR_BIT] = line_dir_up;
		status_word[ccvg_pkg::STAT_FLASH_LSB] = flash_count_q0;
		status_word[ccvg_pkg::STAT_FLASH_LSB + 1] = flash_count_q1;
	end

	// read channel: one read in flight, data registered
	assign rd_go = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = rd_go;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= ccvg_pkg::RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rresp_q <= ccvg_pkg::RESP_OKAY;
			case (s_axi_araddr)
				ccvg_pkg::ADDR_ELEM: rdata_q <= 32'(elem_coord_q);
				ccvg_pkg::ADDR_LINE: rdata_q <= line_to_word(line_reg_q);
				ccvg_pkg::ADDR_STAT: rdata_q <= status_word;
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= ccvg_pkg::RESP_DECERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

endmodule

/* dv/ccvg_raster_model.sv */
// raster timing source standing in for the display timing logic
module ccvg_raster_model #(
	parameter int H_VIS = 40,
	parameter int H_TOT = 48,
	parameter int V_VIS = 24,
	parameter int V_TOT = 27
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// raster timing out
	output ccvg_pkg::ccvg_timing_t timing
);
	int hc;
	int vc;

	// short raster keeps a field near 1300 cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			hc <= 0;
			vc <= 0;
			timing <= 5'h00;
		end else begin
			hc <= (hc == H_TOT - 1) ? 0 : hc + 1;
			if (hc == H_TOT - 1)
				vc <= (vc == V_TOT - 1) ? 0 : vc + 1;
			timing.horiz_blank_level <= hc >= H_VIS;
			timing.horiz_mem_sync_pulse <= hc == H_VIS + 2;
			timing.vert_blank_level <= vc >= V_VIS;
			timing.vert_mem_sync_pulse <= hc == H_VIS + 2 && vc == V_TOT - 1;
			if (hc == 0 && vc == V_VIS)
				timing.odd_field <= !timing.odd_field;
		end
	end
endmodule

/* dv/ccvg_sva.sv */
// port assertions for the cursor generator register slave
module ccvg_sva #(
	parameter int FIELDS_PER_STEP = 15
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_wr; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
	property p_pair; s_axi_awready |-> s_axi_wready && s_axi_wvalid; endproperty
	property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_ro;
		s_axi_awready && s_axi_awaddr == 4'h8 |=> s_axi_bresp == ccvg_pkg::RESP_DECERR;
	endproperty
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_unmap;
		s_axi_arready && s_axi_araddr == 4'hC |=>
			s_axi_rresp == ccvg_pkg::RESP_DECERR && s_axi_rdata == 32'h0;
	endproperty

	a_wr: assert property (p_wr) else $error("write not answered");
	a_pair: assert property (p_pair) else $error("write halves split");
	a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	a_ro: assert property (p_ro) else $error("status write accepted");
	a_rd: assert property (p_rd) else $error("read not answered");
	a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	a_unmap: assert property (p_unmap) else $error("unmapped read accepted");

	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == ccvg_pkg::RESP_DECERR);
endmodule

/* dv/tb_ccvg_top.sv */
// self-checking bench for the crosshair cursor generator
module tb_ccvg_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0;
	logic aresetn = 0;
	ccvg_pkg::ccvg_timing_t timing;
	logic cursor_video, awready, wready, bvalid, arready, rvalid, cmp_on = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int err_total = 0, n_checks = 0;
	logic [9:0] ex = 10'h000, e;
	logic [15:0] lr = 16'h0000;
	logic [8:0] l;
	logic ed, ld, vbq, bump, vid;
	logic [1:0] fc;
	logic [31:0] cfg_e [3] = '{32'h10, 32'h5, 32'h10};
	logic [31:0] cfg_l [3] = '{32'h8008, 32'hC009, 32'h4008};

	always #5 aclk = ~aclk;

	ccvg_top #(.FIELDS_PER_STEP(1)) dut_u (.aclk(aclk), .aresetn(aresetn), .timing(timing),
		.cursor_video(cursor_video), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ccvg_raster_model ras_u (.aclk(aclk), .aresetn(aresetn), .timing(timing));

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// bready is up from the start, so the answer is taken at once
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (i = 0; i < 50 && !bvalid; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end
		if (i == 50) begin
			err_total++;
			test_done();
		end
		chk(bresp, r);
		bready <= 0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (i = 0; i < 50 && !rvalid; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end
		if (i == 50) begin
			err_total++;
			test_done();
		end
		chk(rdata, d);
		chk(rresp, r);
		rready <= 0;
		@(posedge aclk);
	endtask

	// reference cursor from the raster and the stored coordinates
	always @(posedge aclk) begin
		if (!aresetn) begin
			{e, l, ed, ld, vbq, bump, fc, vid} <= 26'h0;
		end else begin
			vbq <= timing.vert_blank_level;
			if (timing.horiz_mem_sync_pulse) begin
				e <= ex;
				ed <= 0;
			end else if (!timing.horiz_blank_level) begin
				if (!ed && e == 0) ed <= 1;
				else e <= ed ? e + 1 : e - 1;
			end
			bump <= 0;
			if (timing.vert_mem_sync_pulse) begin
				l <= lr[8:0];
				ld <= 0;
				bump <= timing.odd_field & lr[0];
				fc <= fc + 1;
			end else if (bump) begin
				l <= l + 1;
			end else if (timing.horiz_mem_sync_pulse && !vbq) begin
				if (!ld && l == 0) begin
					ld <= 1;
					l <= 1;
				end else l <= ld ? l + 1 : l - 1;
			end
			vid <= ((e[9:3] == 0 && e[2:0] != 7 && l[2:1] == 0) | (l[8:3] == 0 && e[2:0] == 0))
				& lr[15] & (!lr[14] | fc != 0);
		end
	end

	always @(posedge aclk) if (cmp_on) chk(cursor_video, vid);

	initial begin
		int k;
		int i;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(4'h0, 32'h0, ccvg_pkg::RESP_OKAY);
		// element counter runs from release: zero held, reversed, then at 3
		rd(4'h8, 32'h0400_0003, ccvg_pkg::RESP_OKAY);
		rd(4'hC, 32'h0, ccvg_pkg::RESP_DECERR);
		wr(4'h8, 32'h1, ccvg_pkg::RESP_DECERR);
		wr(4'hC, 32'h1, ccvg_pkg::RESP_DECERR);
		for (k = 0; k < 3; k++) begin
			cmp_on <= 0;
			wr(4'h0, cfg_e[k], ccvg_pkg::RESP_OKAY);
			wr(4'h4, cfg_l[k], ccvg_pkg::RESP_OKAY);
			rd(4'h4, cfg_l[k], ccvg_pkg::RESP_OKAY);
			ex <= cfg_e[k][9:0];
			lr <= cfg_l[k][15:0];
			for (i = 0; i < 3000 && !timing.vert_mem_sync_pulse; i++)
				@(posedge aclk);
			if (i == 3000) begin
				err_total++;
				test_done();
			end
			@(posedge aclk);
			cmp_on <= 1;
			repeat (5200) @(posedge aclk);
		end
		test_done();
	end
endmodule

bind ccvg_top ccvg_sva #(.FIELDS_PER_STEP(FIELDS_PER_STEP)) sva_u (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
